/* File: rtl/scs_pkg.sv */
// shared constants, config layout and types for the serial clock synthesizer
package scs_pkg;

   // ==========================================
   // sizes
   localparam int CFG_BITS = 160;
   localparam int NUM_PLL = 4;
   localparam int NUM_DIV = 6;
   localparam int NUM_OUT = 9;
   localparam int PER_BITS = 16;
   localparam int ACC_BITS = 28;

   // ==========================================
   // pin positions in the synchroniser vector
   localparam int IN_DATA = 0;
   localparam int IN_SHIFT = 1;
   localparam int IN_STROBE = 2;
   localparam int IN_PD = 3;
   localparam int IN_REF = 4;
   localparam int IN_BITS = 5;

   // ==========================================
   // field values
   localparam logic [4:0] RATIO_MIN = 5'h02;
   localparam logic [4:0] RATIO_MAX = 5'h14;
   localparam logic [2:0] SEL_REF = 3'h6;
   localparam logic [2:0] SEL_OFF = 3'h7;
   localparam logic [15:0] PER_MAX = 16'hffff;

   // ==========================================
   // timing
   localparam int LOCK_TIME_MS = 10;
   localparam longint SYS_CLK_HZ = 200000000;
   localparam int LOCK_CYCLES = int'(LOCK_TIME_MS * SYS_CLK_HZ / 1000);

   // ==========================================
   // configuration word, msb first on the wire
   typedef struct packed {
      logic [10:0] m_minus1;
      logic [9:0] n_minus1;
   } scs_pll_cfg_t;

   typedef struct packed {
      logic [1:0] src;
      logic [4:0] ratio;
   } scs_div_cfg_t;

   typedef struct packed {
      logic [6:0] spare;
      scs_pll_cfg_t [3:0] pll;
      scs_div_cfg_t [5:0] div;
      logic [8:0][2:0] sel;
   } scs_cfg_t;

   localparam scs_cfg_t CFG_RESET = '0;

   typedef enum logic {ST_IDLE, ST_LOCKING} scs_lock_t;

   // output divider value held within 2..20
   function automatic logic [4:0] scs_ratio_eff(input logic [4:0] r);
      if (r < RATIO_MIN) begin
         return RATIO_MIN;
      end else if (r > RATIO_MAX) begin
         return RATIO_MAX;
      end
      return r;
   endfunction : scs_ratio_eff

endpackage : scs_pkg

/* File: rtl/scs_pll.sv */
// digital frequency synthesis loop: tick rate is ref * m / n
`timescale 1ns/1ps
`default_nettype none
module scs_pll (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic [15:0] period,
   input wire scs_pkg::scs_pll_cfg_t cfg,
   output logic tick
);
   import scs_pkg::*;

   logic [ACC_BITS-1:0] acc;
   logic [ACC_BITS-1:0] limit;
   logic [ACC_BITS-1:0] sum;
   logic [11:0] m_eff;
   logic [10:0] n_eff;

   assign m_eff = {1'b0, cfg.m_minus1} + 12'h001;
   assign n_eff = {1'b0, cfg.n_minus1} + 11'h001;
   // n reference periods span period*n steps of m
   assign limit = ACC_BITS'(period) * ACC_BITS'(n_eff);
   assign sum = acc + ACC_BITS'(m_eff);

   always_ff @(posedge clk) begin
      if (rst || !run) begin
         acc <= '0;
         tick <= 1'b0;
      end else if (sum >= limit) begin
         acc <= sum - limit;
         tick <= 1'b1;
      end else begin
         acc <= sum;
         tick <= 1'b0;
      end
   end

   property p_pll_tick;
      @(posedge clk) disable iff (rst)
      run && (sum >= limit) |=> tick;
   endproperty
   a_pll_tick: assert property (p_pll_tick)
      else $error("pll tick missed");

   property p_pll_range;
      @(posedge clk) disable iff (rst)
      run && ACC_BITS'(m_eff) <= limit |-> acc < limit;
   endproperty
   a_pll_range: assert property (p_pll_range)
      else $error("pll accumulator escaped its limit");

endmodule : scs_pll
`default_nettype wire

/* File: rtl/scs_odiv.sv */
// output divider: divides pll ticks by 2..20, near 50% duty
`timescale 1ns/1ps
`default_nettype none
module scs_odiv (
   input wire logic clk,
   input wire logic rst,
   input wire logic restart,
   input wire logic tick,
   input wire logic [4:0] ratio,
   output logic level
);
   import scs_pkg::*;

   logic [4:0] cnt;
   logic [4:0] next_cnt;

   assign next_cnt = (cnt >= ratio - 5'h01) ? 5'h00 : cnt + 5'h01;

   always_ff @(posedge clk) begin
      if (rst || restart) begin
         cnt <= 5'h00;
         level <= 1'b0;
      end else if (tick) begin
         cnt <= next_cnt;
         level <= next_cnt < (ratio >> 1);
      end
   end

   property p_div_wrap;
      @(posedge clk) disable iff (rst)
      tick && !restart && cnt == ratio - 5'h01 |=> cnt == 5'h00 && level;
   endproperty
   a_div_wrap: assert property (p_div_wrap)
      else $error("divider did not wrap at ratio");

endmodule : scs_odiv
`default_nettype wire

/* File: rtl/scs_clock_synth.sv */
// serial configured quad pll clock synthesizer, digital model
`timescale 1ns/1ps
`default_nettype none
module scs_clock_synth #(
   parameter int unsigned LOCK_WAIT = scs_pkg::LOCK_CYCLES
) (
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic SERIAL_DATA,
   input wire logic SHIFT_CLOCK,
   input wire logic LOAD_STROBE,
   input wire logic POWER_DOWN_TRISTATE_N,
   input wire logic REFERENCE_INPUT,
   output logic [8:0] OUTPUT_CLOCK,
   output logic [8:0] OUTPUT_CLOCK_OE
);
   import scs_pkg::*;

   // ==========================================
   // input synchronisers
   logic [IN_BITS-1:0] pins;
   logic [IN_BITS-1:0] sync1;
   logic [IN_BITS-1:0] sync2;
   logic [IN_BITS-1:0] sync3;
   logic data_s;
   logic strobe_s;
   logic pd_s;
   logic ref_s;
   logic shift_rise;
   logic strobe_rise;
   logic ref_rise;

   assign pins[IN_DATA] = SERIAL_DATA;
   assign pins[IN_SHIFT] = SHIFT_CLOCK;
   assign pins[IN_STROBE] = LOAD_STROBE;
   assign pins[IN_PD] = POWER_DOWN_TRISTATE_N;
   assign pins[IN_REF] = REFERENCE_INPUT;

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign data_s = sync2[IN_DATA];
   assign strobe_s = sync2[IN_STROBE];
   assign pd_s = sync2[IN_PD];
   assign ref_s = sync2[IN_REF];
   assign shift_rise = sync2[IN_SHIFT] && !sync3[IN_SHIFT];
   assign strobe_rise = strobe_s && !sync3[IN_STROBE];
   assign ref_rise = ref_s && !sync3[IN_REF];

   // ==========================================
   // serial shift register and transparent latch
   logic [CFG_BITS-1:0] shift_reg;
   logic [CFG_BITS-1:0] next_shift;
   scs_cfg_t cfg_latch;
   logic load_evt;

   assign next_shift = shift_rise ?
      {shift_reg[CFG_BITS-2:0], data_s} : shift_reg;
   assign load_evt = strobe_s && (strobe_rise || shift_rise);

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         shift_reg <= '0;
      end else begin
         shift_reg <= next_shift;
      end
   end

   // follows the shifter whenever load is high
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         cfg_latch <= CFG_RESET;
      end else if (strobe_s) begin
         cfg_latch <= scs_cfg_t'(next_shift);
      end
   end

   // ==========================================
   // relock timer: new settings take over after the lock time
   scs_lock_t state;
   logic [31:0] lock_cnt;
   logic apply_now;
   scs_cfg_t active;
   logic configured;

   assign apply_now = state == ST_LOCKING && lock_cnt == 32'h0 &&
      !load_evt;

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         state <= ST_IDLE;
         lock_cnt <= 32'h0;
      end else if (load_evt) begin
         state <= ST_LOCKING;
         lock_cnt <= 32'(LOCK_WAIT - 1);
      end else begin
         case (state)
            ST_LOCKING: begin
               if (lock_cnt == 32'h0) begin
                  state <= ST_IDLE;
               end else begin
                  lock_cnt <= lock_cnt - 32'h1;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         active <= CFG_RESET;
         configured <= 1'b0;
      end else if (apply_now) begin
         active <= cfg_latch;
         configured <= 1'b1;
      end
   end

   // ==========================================
   // reference period measurement
   logic [PER_BITS-1:0] per_cnt;
   logic [PER_BITS-1:0] period;
   logic ref_seen;
   logic period_ok;
   logic run;

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         per_cnt <= '0;
         period <= '0;
         ref_seen <= 1'b0;
         period_ok <= 1'b0;
      end else if (ref_rise) begin
         per_cnt <= '0;
         ref_seen <= 1'b1;
         if (ref_seen) begin
            period <= per_cnt + 16'h0001;
            period_ok <= 1'b1;
         end
      end else if (per_cnt != PER_MAX) begin
         per_cnt <= per_cnt + 16'h0001;
      end
   end

   // synthesis halts while powered down
   assign run = pd_s && period_ok;

   // ==========================================
   // four plls and six output divider units
   logic [NUM_PLL-1:0] pll_tick;
   logic [NUM_DIV-1:0] div_level;
   logic [NUM_DIV-1:0] restart;
   logic div_rst;

   assign div_rst = RESET || !pd_s;

   genvar gp;
   generate
      for (gp = 0; gp < NUM_PLL; gp++) begin : g_pll
         scs_pll u_pll (
            .clk(SYS_CLK),
            .rst(RESET),
            .run(run),
            .period(period),
            .cfg(active.pll[gp]),
            .tick(pll_tick[gp])
         );
      end
   endgenerate

   genvar gd;
   generate
      for (gd = 0; gd < NUM_DIV; gd++) begin : g_div
         // a changed divider restarts; same divider keeps phase
         assign restart[gd] = apply_now &&
            scs_ratio_eff(cfg_latch.div[gd].ratio) !=
            scs_ratio_eff(active.div[gd].ratio);
         scs_odiv u_odiv (
            .clk(SYS_CLK),
            .rst(div_rst),
            .restart(restart[gd]),
            .tick(pll_tick[active.div[gd].src]),
            .ratio(scs_ratio_eff(active.div[gd].ratio)),
            .level(div_level[gd])
         );
      end
   endgenerate

   // ==========================================
   // output selection: one of six units, reference or off
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         OUTPUT_CLOCK <= '0;
      end else begin
         for (int k = 0; k < NUM_OUT; k++) begin
            if (!configured) begin
               OUTPUT_CLOCK[k] <= ref_s;
            end else begin
               case (active.sel[k])
                  SEL_REF: OUTPUT_CLOCK[k] <= ref_s;
                  SEL_OFF: OUTPUT_CLOCK[k] <= 1'b0;
                  default: begin
                     OUTPUT_CLOCK[k] <= div_level[active.sel[k]];
                  end
               endcase
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         OUTPUT_CLOCK_OE <= '0;
      end else begin
         OUTPUT_CLOCK_OE <= {NUM_OUT{pd_s}};
      end
   end

   // ==========================================
   // assertions
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RESET);

   property p_shift_msb;
      shift_rise |=>
         shift_reg == {$past(shift_reg[CFG_BITS-2:0]), $past(data_s)};
   endproperty
   a_shift_msb: assert property (p_shift_msb)
      else $error("shift register did not take data at lsb");

   property p_shift_hold;
      !shift_rise |=> $stable(shift_reg);
   endproperty
   a_shift_hold: assert property (p_shift_hold)
      else $error("shift register moved without shift edge");

   property p_latch_follow;
      strobe_s |=> cfg_latch == $past(next_shift);
   endproperty
   a_latch_follow: assert property (p_latch_follow)
      else $error("latch not transparent while load high");

   property p_latch_hold;
      !strobe_s |=> $stable(cfg_latch);
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("latch changed while load low");

   property p_lock_start;
      load_evt |=> state == ST_LOCKING && lock_cnt == 32'(LOCK_WAIT - 1);
   endproperty
   a_lock_start: assert property (p_lock_start)
      else $error("relock timer not started by load");

   property p_apply;
      apply_now |=> configured && active == $past(cfg_latch);
   endproperty
   a_apply: assert property (p_apply)
      else $error("latched word not applied at lock end");

   property p_tristate;
      !pd_s |=> OUTPUT_CLOCK_OE == '0;
   endproperty
   a_tristate: assert property (p_tristate)
      else $error("outputs driven while powered down");

   property p_drive;
      pd_s ##1 pd_s |-> OUTPUT_CLOCK_OE == '1;
   endproperty
   a_drive: assert property (p_drive)
      else $error("outputs not driven after power up");

   property p_default_ref;
      !configured |=> OUTPUT_CLOCK == {NUM_OUT{$past(ref_s)}};
   endproperty
   a_default_ref: assert property (p_default_ref)
      else $error("unprogrammed output is not the reference");

   // unchanged ratio: divider level must survive the switch-over
   property p_smooth;
      apply_now && pd_s && !pll_tick[active.div[0].src] &&
      scs_ratio_eff(cfg_latch.div[0].ratio) ==
      scs_ratio_eff(active.div[0].ratio) |=>
         div_level[0] == $past(div_level[0]);
   endproperty
   a_smooth: assert property (p_smooth)
      else $error("divider restarted with unchanged ratio");

   property p_route;
      configured && active.sel[0] < SEL_REF |=>
         OUTPUT_CLOCK[0] == $past(div_level[active.sel[0]]);
   endproperty
   a_route: assert property (p_route)
      else $error("output not fed by selected divider unit");

   c_load: cover property (strobe_rise ##1 state == ST_LOCKING);
   c_apply: cover property (apply_now ##1 configured);
   c_powerdown: cover property (configured && !pd_s ##1 pd_s);

endmodule : scs_clock_synth
`default_nettype wire

/* File: test/scs_ctrl_model.sv */
// behavioural controller driving the three-wire configuration port
`timescale 1ns/1ps
`default_nettype none
module scs_ctrl_model (
   input wire logic clk,
   output logic sclk,
   output logic sdata,
   output logic strobe
);
   // ==========================================
   // idle levels, shift clock parked low between frames
   initial begin
      sclk = 1'b0;
      sdata = 1'b0;
      strobe = 1'b0;
   end

   // half of the 160 ns shift clock period
   task automatic half;
      repeat (16) @(negedge clk);
   endtask : half

   // data set half a period before the rise, held half a period after
   task automatic shift_one(input logic b);
      sdata = b;
      half();
      sclk = 1'b1;
      half();
      sclk = 1'b0;
   endtask : shift_one

   // whole word msb first; load stays low unless asked to hold it high
   task automatic send_word(input logic [159:0] w, input logic keep_load);
      if (keep_load) strobe = 1'b1;
      for (int i = 159; i >= 0; i--) begin
         shift_one(w[i]);
      end
      sdata = ~w[0];
      if (keep_load) strobe = 1'b0;
   endtask : send_word

   // load pulse of 80 ns after the last bit
   task automatic load_pulse;
      strobe = 1'b1;
      half();
      strobe = 1'b0;
   endtask : load_pulse
endmodule : scs_ctrl_model
`default_nettype wire

/* File: test/test_serial_clock_synth_config.sv */
// self-checking bench for the serial configured clock synthesizer
`timescale 1ns/1ps
`default_nettype none
module test_serial_clock_synth_config;
   import scs_pkg::*;
   localparam int LW = 60;
   localparam int RC = 8;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic pd_n = 1'b1;
   logic ref_in = 1'b0;
   logic sclk, sdata, strobe;
   logic [8:0] out_clk, out_oe;
   logic [2:0] r_hist = '0;
   logic [2:0] p_hist = '0;
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;
   int m_v[4], n_v[4], r_v[6], s_v[6], sel_v[9];
   scs_cfg_t cfg;

   scs_clock_synth #(.LOCK_WAIT(LW)) i_dut (
      .SYS_CLK(sys_clk), .RESET(reset), .SERIAL_DATA(sdata),
      .SHIFT_CLOCK(sclk), .LOAD_STROBE(strobe),
      .POWER_DOWN_TRISTATE_N(pd_n), .REFERENCE_INPUT(ref_in),
      .OUTPUT_CLOCK(out_clk), .OUTPUT_CLOCK_OE(out_oe));
   scs_ctrl_model i_ctrl (.clk(sys_clk), .sclk(sclk), .sdata(sdata),
      .strobe(strobe));

   // ==========================================
   // clocks, input history, timeout
   always #2.5 sys_clk = ~sys_clk;
   always begin
      repeat (RC / 2) @(negedge sys_clk);
      ref_in = ~ref_in;
   end
   always @(posedge sys_clk) begin
      r_hist <= {r_hist[1:0], ref_in};
      p_hist <= {p_hist[1:0], pd_n};
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         fail_count++;
         stop_test();
      end
   end

   // ==========================================
   // checks
   task automatic stop_test;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic cmp_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: level %b expected %b", $time, got, exp);
      end
   endtask : cmp_bit

   task automatic cmp_num(input int got, input int exp);
      compares++;
      if (got != exp) begin
         fail_count++;
         $display("Error at %0t: cycles %0d expected %0d", $time, got, exp);
      end
   endtask : cmp_num

   // enables against power-down, chosen outputs against ref or low
   task automatic watch(input logic [8:0] rm, input logic [8:0] om,
                        input int n);
      repeat (n) begin
         @(negedge sys_clk);
         cmp_bit(&out_oe, p_hist[2]);
         cmp_bit(|out_oe, p_hist[2]);
         for (int i = 0; i < 9; i++) begin
            if (rm[i]) cmp_bit(out_clk[i], r_hist[2]);
            if (om[i]) cmp_bit(out_clk[i], 1'b0);
         end
      end
   endtask : watch

   // period and high time of one output, after two settling rises
   task automatic measure(input int i, output int per, output int hi);
      int t;
      per = 0;
      hi = 0;
      t = 0;
      repeat (2) begin
         while (out_clk[i] !== 1'b0 && t < 2000) begin
            @(negedge sys_clk);
            t++;
         end
         while (out_clk[i] !== 1'b1 && t < 2000) begin
            @(negedge sys_clk);
            t++;
         end
      end
      while (out_clk[i] === 1'b1 && t < 3000) begin
         hi++;
         per++;
         @(negedge sys_clk);
         t++;
      end
      while (out_clk[i] === 1'b0 && t < 4000) begin
         per++;
         @(negedge sys_clk);
         t++;
      end
   endtask : measure

   // ==========================================
   // model of the configuration and its expected outputs
   task automatic make_cfg(input bit first);
      cfg = CFG_RESET;
      for (int k = 0; k < 4; k++) begin
         m_v[k] = (k == 3) ? 2048 : 1 + $urandom_range(1, 0);
         n_v[k] = (k == 3) ? 1024 : 1 + $urandom_range(2, 0);
         cfg.pll[k].m_minus1 = 11'(m_v[k] - 1);
         cfg.pll[k].n_minus1 = 10'(n_v[k] - 1);
      end
      for (int j = 0; j < 6; j++) begin
         r_v[j] = (first && j < 2) ? 2 + 18 * j : $urandom_range(20, 2);
         s_v[j] = (first && j == 1) ? 3 : $urandom_range(3, 0);
         cfg.div[j].ratio = 5'(r_v[j]);
         cfg.div[j].src = 2'(s_v[j]);
      end
      for (int i = 0; i < 9; i++) begin
         sel_v[i] = (i + (first ? 0 : 3)) % 8;
         cfg.sel[i] = 3'(sel_v[i]);
      end
   endtask : make_cfg

   task automatic check_cfg;
      int per, hi, tk, u;
      logic [8:0] rm, om;
      rm = '0;
      om = '0;
      for (int i = 0; i < 9; i++) begin
         u = sel_v[i];
         if (u == 6) rm[i] = 1'b1;
         else if (u == 7) om[i] = 1'b1;
         else begin
            tk = RC * n_v[s_v[u]] / m_v[s_v[u]];
            measure(i, per, hi);
            cmp_num(per, tk * r_v[u]);
            cmp_num(hi, tk * (r_v[u] / 2));
         end
      end
      watch(rm, om, 64);
   endtask : check_cfg

   // ==========================================
   // main sequence
   initial begin
      void'($urandom(32'h9506));
      repeat (4) @(negedge sys_clk);
      reset = 1'b0;
      repeat (2) @(negedge sys_clk);
      watch('1, '0, 64);
      make_cfg(1'b1);
      repeat (8) i_ctrl.shift_one(1'($urandom));
      i_ctrl.send_word(cfg, 1'b0);
      i_ctrl.load_pulse();
      watch('1, '0, LW - 30);
      repeat (30) @(negedge sys_clk);
      check_cfg();
      pd_n = 1'b0;
      watch('0, '0, 16);
      make_cfg(1'b0);
      i_ctrl.send_word(cfg, 1'b1);
      watch('0, '0, LW + 8);
      pd_n = 1'b1;
      repeat (8) @(negedge sys_clk);
      check_cfg();
      stop_test();
   end
endmodule : test_serial_clock_synth_config
`default_nettype wire
